//--- pbc_buf2.sv
// pbc_buf2.sv: small valid/ready buffer in front of the transmit crossing
`timescale 1ns/10ps
module pbc_buf2
  import pbc_pkg::*;
#(
  parameter int WIDTH = PBC_BYTE_W,
  parameter int DEPTH = PBC_BUF_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  input  wire logic             out_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // ready is registered so the source sees a clean flop
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  // occupancy after this cycle
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // pointers, count and full flag
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q     <= '0;
      rd_q     <= '0;
      cnt_q    <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= nxt(wr_q);
      end
      if (pop) begin
        rd_q <= nxt(rd_q);
      end
      cnt_q    <= cnt_d;
      in_ready <= (cnt_d != (AW+1)'(DEPTH));
    end
  end

  // storage needs no reset, only valid entries are read
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule // pbc_buf2

//--- pbc_hdb3_enc.sv
// pbc_hdb3_enc.sv: bipolar zero-substitution encoder on the line clock
`timescale 1ns/10ps
module pbc_hdb3_enc
  import pbc_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic bit_in,
  output logic      pos_q,
  output logic      neg_q
);
  pbc_sym_t pipe_q [4];
  pbc_sym_t head;
  logic     pol_q;    // last pulse polarity, 1 = positive
  logic     par_q;    // odd pulse count since last violation
  logic     par_eff;
  logic     run4;
  logic     zslot;
  logic [2:0] zcnt_q;
  logic     lastp_q;
  logic     lastv_q;
  logic     seenp_q;
  logic     seenv_q;
  logic     viol_out;

  // parity as it stands once the head symbol is on the line
  always_comb begin
    head    = pipe_q[3];
    par_eff = (head == PBC_SYM_VIOL) ? 1'b0 : (par_q ^ (head != PBC_SYM_ZERO));
    run4    = !bit_in && (pipe_q[0] == PBC_SYM_ZERO) && (pipe_q[1] == PBC_SYM_ZERO)
              && (pipe_q[2] == PBC_SYM_ZERO);
  end

  // four-deep look-ahead; a fourth zero rewrites the block in place
  // reset fills with marks so no long zero run follows reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pipe_q[0] <= PBC_SYM_MARK;
      pipe_q[1] <= PBC_SYM_MARK;
      pipe_q[2] <= PBC_SYM_MARK;
      pipe_q[3] <= PBC_SYM_MARK;
    end else begin
      pipe_q[0] <= run4 ? PBC_SYM_VIOL : (bit_in ? PBC_SYM_MARK : PBC_SYM_ZERO);
      pipe_q[1] <= pipe_q[0];
      pipe_q[2] <= pipe_q[1];
      pipe_q[3] <= (run4 && !par_eff) ? PBC_SYM_BPOL : pipe_q[2];
    end
  end

  // polarity stage: marks alternate, violations repeat the last sign
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_q <= 1'b0;
      neg_q <= 1'b0;
      pol_q <= 1'b0;
      par_q <= 1'b0;
    end else begin
      case (head)
        PBC_SYM_MARK, PBC_SYM_BPOL: begin
          pol_q <= !pol_q;
          pos_q <= !pol_q;
          neg_q <= pol_q;
          par_q <= !par_q;
        end
        PBC_SYM_VIOL: begin
          pos_q <= pol_q;
          neg_q <= !pol_q;
          par_q <= 1'b0;
        end
        default: begin
          pos_q <= 1'b0;
          neg_q <= 1'b0;
        end
      endcase
    end
  end

  // ********************************************************************
  // checks on the line output
  // ********************************************************************
  assign viol_out = (pos_q || neg_q) && seenp_q && (pos_q == lastp_q);
  assign zslot    = !(pos_q || neg_q);

  // helper: zero run length, last pulse and last violation sign
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      zcnt_q  <= 3'h0;
      lastp_q <= 1'b0;
      lastv_q <= 1'b0;
      seenp_q <= 1'b0;
      seenv_q <= 1'b0;
    end else begin
      zcnt_q <= zslot ? ((zcnt_q == 3'h7) ? zcnt_q : zcnt_q + 3'h1) : 3'h0;
      if (pos_q || neg_q) begin
        lastp_q <= pos_q;
        seenp_q <= 1'b1;
      end
      if (viol_out) begin
        lastv_q <= pos_q;
        seenv_q <= 1'b1;
      end
    end
  end

  chk_no_dual_drive: assert property (@(posedge clk) disable iff (!arst_n)
    !(pos_q && neg_q)) else $error("both line polarities driven");
  chk_zero_run_max: assert property (@(posedge clk) disable iff (!arst_n)
    zcnt_q < 3'h4) else $error("four or more zeros on the line");
  chk_viol_alternate: assert property (@(posedge clk) disable iff (!arst_n)
    (viol_out && seenv_q) |-> (pos_q != lastv_q)) else $error("violations not alternating");
endmodule // pbc_hdb3_enc

//--- pbc_line_codec.sv
// pbc_line_codec.sv: top of the bipolar line codec, path side and line side
`timescale 1ns/10ps
module pbc_line_codec
  import pbc_pkg::*;
#(
  parameter int unsigned AIS_LIMIT_CYC = PBC_AIS_CYC
) (
  input  wire logic       MCLK,
  input  wire logic       ARST_N,
  input  wire logic       LINE_CLK,
  input  wire logic       RATE_SEL,
  input  wire logic       MON_EN,
  input  wire logic [7:0] TX_DATA,
  input  wire logic       TX_VALID,
  output logic            TX_READY,
  output logic            TX_POS,
  output logic            TX_NEG,
  input  wire logic       RX_POS,
  input  wire logic       RX_NEG,
  output logic      [7:0] RX_DATA,
  output logic            RX_VALID,
  output logic            RX_BCLK,
  output logic            SIGNAL_LOSS_DEFECT,
  output logic            LOS_REPORT
);
  // ********************************************************************
  // declarations
  // ********************************************************************
  logic [1:0]  lrst_q;
  logic        lrst_n;
  logic [4:0]  ms1_q;
  logic [4:0]  ms2_q;
  logic [1:0]  ms3_q;
  logic        rate_m;
  logic        mon_m;
  logic        los_m;
  logic        rx_evt;
  logic        take_evt;
  logic [3:0]  ls1_q;
  logic [3:0]  ls2_q;
  logic        put3_q;
  logic        rate_l;
  logic        put_evt;
  logic        rpos_l;
  logic        rneg_l;
  logic        bv;
  logic [7:0]  bd;
  logic [7:0]  hold_q;
  logic        hold_full_q;
  logic        put_q;
  logic        take_q;
  logic        have_q;
  logic [2:0]  tcnt_q;
  logic [7:0]  tsh_q;
  logic        avail;
  logic        mark;
  logic        viol;
  logic        rbit;
  logic        lpol_q;
  logic        seen_q;
  logic [2:0]  dq_q;
  logic [2:0]  rcnt_q;
  logic [7:0]  rsh_q;
  logic [7:0]  rbyte_q;
  logic        rxt_q;
  logic [9:0]  los_lim;
  logic [9:0]  zrun_q;
  logic [9:0]  zrun_d;
  logic        los_q;
  pbc_rxmode_t rxst_q;
  logic [31:0] acc_q;
  logic [32:0] acc_sum;
  logic [2:0]  abit_q;
  logic        astb;

  // ********************************************************************
  // resets and synchronisers
  // ********************************************************************
  // line-side reset: asserts at once, releases on the line clock
  always_ff @(posedge LINE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lrst_q <= 2'h0;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end
  assign lrst_n = lrst_q[1];

  // MCLK side: rate, monitor, loss, rx byte toggle, tx take toggle
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ms1_q <= 5'h00;
      ms2_q <= 5'h00;
      ms3_q <= 2'h0;
    end else begin
      ms1_q <= {RATE_SEL, MON_EN, los_q, rxt_q, take_q};
      ms2_q <= ms1_q;
      ms3_q <= ms2_q[1:0];
    end
  end
  assign rate_m   = ms2_q[4];
  assign mon_m    = ms2_q[3];
  assign los_m    = ms2_q[2];
  assign rx_evt   = ms2_q[1] ^ ms3_q[1];
  assign take_evt = ms2_q[0] ^ ms3_q[0];

  // line side: rate, tx put toggle, received line pulses
  always_ff @(posedge LINE_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      ls1_q  <= 4'h0;
      ls2_q  <= 4'h0;
      put3_q <= 1'b0;
    end else begin
      ls1_q  <= {RATE_SEL, put_q, RX_POS, RX_NEG};
      ls2_q  <= ls1_q;
      put3_q <= ls2_q[2];
    end
  end
  assign rate_l  = ls2_q[3];
  assign put_evt = ls2_q[2] ^ put3_q;
  assign rpos_l  = ls2_q[1];
  assign rneg_l  = ls2_q[0];

  // ********************************************************************
  // transmit: buffer, byte crossing, serialiser, encoder
  // ********************************************************************
  pbc_buf2 #(
    .WIDTH (PBC_BYTE_W),
    .DEPTH (PBC_BUF_DEPTH)
  ) u_txbuf (
    .clk       (MCLK),
    .arst_n    (ARST_N),
    .in_valid  (TX_VALID),
    .in_data   (TX_DATA),
    .in_ready  (TX_READY),
    .out_ready (!hold_full_q),
    .out_valid (bv),
    .out_data  (bd)
  );

  // hold register is only rewritten after the line side gave it back
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hold_q      <= PBC_IDLE_BYTE;
      hold_full_q <= 1'b0;
      put_q       <= 1'b0;
    end else if (bv && !hold_full_q) begin
      hold_q      <= bd;
      hold_full_q <= 1'b1;
      put_q       <= !put_q;
    end else if (take_evt) begin
      hold_full_q <= 1'b0;
    end
  end

  // serialiser, lsb first; an empty hold sends idle ones, the line cannot stall
  assign avail = have_q || put_evt;
  always_ff @(posedge LINE_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      tcnt_q <= 3'h0;
      tsh_q  <= PBC_IDLE_BYTE;
      have_q <= 1'b0;
      take_q <= 1'b0;
    end else begin
      tcnt_q <= tcnt_q + 3'h1;
      if (tcnt_q == PBC_LAST_BIT) begin
        tsh_q  <= avail ? hold_q : PBC_IDLE_BYTE;
        have_q <= 1'b0;
        take_q <= avail ? !take_q : take_q;
      end else begin
        tsh_q  <= {1'b1, tsh_q[7:1]};
        have_q <= avail;
      end
    end
  end

  pbc_hdb3_enc u_enc (
    .clk    (LINE_CLK),
    .arst_n (lrst_n),
    .bit_in (tsh_q[0]),
    .pos_q  (TX_POS),
    .neg_q  (TX_NEG)
  );

  // ********************************************************************
  // receive: decoder, loss detector, byte assembly on the line clock
  // ********************************************************************
  // a pulse of the same sign as the last one is a violation; it and the
  // slot three back (B or zero) both decode as zero
  assign mark = rpos_l || rneg_l;
  assign viol = mark && seen_q && (rpos_l == lpol_q);
  assign rbit = viol ? 1'b0 : dq_q[2];

  always_ff @(posedge LINE_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      lpol_q  <= 1'b0;
      seen_q  <= 1'b0;
      dq_q    <= 3'h0;
      rcnt_q  <= 3'h0;
      rsh_q   <= 8'h00;
      rbyte_q <= 8'h00;
      rxt_q   <= 1'b0;
    end else begin
      dq_q   <= {dq_q[1:0], mark && !viol};
      rcnt_q <= rcnt_q + 3'h1;
      rsh_q  <= {rbit, rsh_q[7:1]};
      if (mark) begin
        lpol_q <= rpos_l;
        seen_q <= 1'b1;
      end
      // byte word stays put for eight line clocks, ample for the MCLK side
      if (rcnt_q == PBC_LAST_BIT) begin
        rbyte_q <= {rbit, rsh_q[7:1]};
        rxt_q   <= !rxt_q;
      end
    end
  end

  // loss: a run of empty slots as long as the rate threshold
  assign los_lim = rate_l ? PBC_LOS_HI : PBC_LOS_LO;
  // saturate with >= so a rate change in mid-silence cannot let the count wrap
  assign zrun_d  = mark ? 10'h000 : ((zrun_q >= los_lim) ? los_lim : zrun_q + 10'h001);
  always_ff @(posedge LINE_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      zrun_q <= 10'h000;
      los_q  <= 1'b0;
    end else begin
      zrun_q <= zrun_d;
      if (mark) begin
        los_q <= 1'b0;
      end else if (zrun_d == los_lim) begin
        los_q <= 1'b1;
      end
    end
  end

  chk_los_detect: assert property (@(posedge LINE_CLK) disable iff (!lrst_n)
    (zrun_q == los_lim) |-> los_q) else $error("silent run did not raise loss");

  // ********************************************************************
  // receive: path side output and substitute stream
  // ********************************************************************
  // mode follows loss one cycle later in both directions
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rxst_q <= PBC_RX_LINE;
    end else begin
      case (rxst_q)
        PBC_RX_LINE:  rxst_q <= los_m ? PBC_RX_ALARM : PBC_RX_LINE;
        PBC_RX_ALARM: rxst_q <= los_m ? PBC_RX_ALARM : PBC_RX_LINE;
        default:      rxst_q <= PBC_RX_LINE;
      endcase
    end
  end

  // phase accumulator gives the nominal bit rate; runs always so the
  // substitute timing starts without a settling phase
  assign acc_sum = {1'b0, acc_q} + {1'b0, rate_m ? PBC_NCO_HI : PBC_NCO_LO};
  assign astb    = acc_sum[32] && (abit_q == PBC_LAST_BIT);
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      acc_q  <= PBC_NCO_RST;
      abit_q <= 3'h0;
    end else begin
      acc_q <= acc_sum[31:0];
      if (acc_sum[32]) begin
        abit_q <= abit_q + 3'h1;
      end
    end
  end

  // byte delivery with byte clock toggle, data or all ones
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RX_DATA  <= 8'h00;
      RX_VALID <= 1'b0;
      RX_BCLK  <= 1'b0;
    end else begin
      RX_VALID <= 1'b0;
      if ((rxst_q == PBC_RX_LINE) && rx_evt) begin
        RX_DATA  <= rbyte_q;
        RX_VALID <= 1'b1;
        RX_BCLK  <= !RX_BCLK;
      end else if ((rxst_q == PBC_RX_ALARM) && astb) begin
        RX_DATA  <= PBC_AIS_BYTE;
        RX_VALID <= 1'b1;
        RX_BCLK  <= !RX_BCLK;
      end
    end
  end

  // loss status and report to equipment management
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SIGNAL_LOSS_DEFECT        <= 1'b0;
      LOS_REPORT <= 1'b0;
    end else begin
      SIGNAL_LOSS_DEFECT        <= los_m;
      LOS_REPORT <= los_m && mon_m;
    end
  end

  // ********************************************************************
  // checks on the path side
  // ********************************************************************
  logic [31:0] wait_q;
  logic [7:0]  gap_q;
  logic        gapok_q;

  // helper: cycles in alarm without a byte, spacing of alarm bytes
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wait_q  <= 32'h0;
      gap_q   <= 8'h00;
      gapok_q <= 1'b0;
    end else begin
      wait_q  <= ((rxst_q == PBC_RX_ALARM) && !RX_VALID) ? wait_q + 32'h1 : 32'h0;
      gap_q   <= RX_VALID ? 8'h01 : ((gap_q == 8'hFF) ? gap_q : gap_q + 8'h01);
      // a line byte launched just as alarm starts must not open a spacing check
      gapok_q <= RX_VALID ? (wait_q != 32'h0) : gapok_q && (rxst_q == PBC_RX_ALARM);
    end
  end

  chk_ais_all_ones: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (RX_VALID && $past(rxst_q == PBC_RX_ALARM)) |-> (RX_DATA == PBC_AIS_BYTE))
    else $error("alarm byte not all ones");
  chk_ais_first_byte: assert property (@(posedge MCLK) disable iff (!ARST_N)
    wait_q < AIS_LIMIT_CYC) else $error("alarm stream late");
  chk_ais_release: assert property (@(posedge MCLK) disable iff (!ARST_N)
    $fell(los_m) |=> (rxst_q == PBC_RX_LINE)) else $error("alarm stream not released");
  chk_ais_rate_lo: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (RX_VALID && gapok_q && !rate_m && $stable(rate_m)) |->
      (gap_q >= 8'(PBC_GAP_LO)) && (gap_q <= 8'(PBC_GAP_LO + 1)))
    else $error("low rate alarm spacing wrong");
  chk_ais_rate_hi: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (RX_VALID && gapok_q && rate_m && $stable(rate_m)) |->
      (gap_q >= 8'(PBC_GAP_HI)) && (gap_q <= 8'(PBC_GAP_HI + 1)))
    else $error("high rate alarm spacing wrong");
  chk_report_mon: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (los_m && mon_m) |=> LOS_REPORT) else $error("loss not reported");
  chk_report_quiet: assert property (@(posedge MCLK) disable iff (!ARST_N)
    !mon_m |=> !LOS_REPORT) else $error("report outside monitoring");
  chk_rx_delivery: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (rx_evt && (rxst_q == PBC_RX_LINE)) |=> (RX_VALID && (RX_DATA == $past(rbyte_q))))
    else $error("decoded byte not delivered");
endmodule // pbc_line_codec

//--- pbc_line_partner.sv
// pbc_line_partner.sv: remote line end, loops the line back and polices the line code
`timescale 1ns/10ps
module pbc_line_partner (
  input  wire logic line_clk,
  input  wire logic tx_pos,
  input  wire logic tx_neg,
  input  wire logic cut,
  output logic      rx_pos,
  output logic      rx_neg,
  output int        code_err
);
  logic last_mark;
  logic last_viol;
  logic seen_mark;
  logic seen_viol;
  int   zrun;
  initial begin
    {rx_pos, rx_neg, last_mark, last_viol, seen_mark, seen_viol} = 6'h00;
    code_err = 0;
    zrun = 0;
  end
  // a cut line carries no pulses at all, which is what real loss looks like
  always @(posedge line_clk) begin
    zrun <= (tx_pos || tx_neg) ? 0 : zrun + 1;
    if ((tx_pos && tx_neg) || (seen_mark && zrun == 3 && !tx_pos && !tx_neg))
      code_err <= code_err + 1;
    if (tx_pos ^ tx_neg) begin
      if (seen_mark && tx_pos == last_mark) begin
        if (seen_viol && tx_pos == last_viol) code_err <= code_err + 1;
        last_viol <= tx_pos;
        seen_viol <= 1'b1;
      end
      last_mark <= tx_pos;
      seen_mark <= 1'b1;
    end
    rx_pos <= #1 tx_pos & ~cut;
    rx_neg <= #1 tx_neg & ~cut;
  end
endmodule // pbc_line_partner

//--- pbc_pkg.sv
// pbc_pkg.sv: shared constants and types of the bipolar line codec
// What this block does
// - Transmit path codes binary data into bipolar order-three line code at both rates.
// - Receive path decodes the line, delivers data bytes with a recovered byte clock.
// - Receive path flags signal loss after a rate-dependent run of empty bit slots.
// - On signal loss, all-ones bytes at nominal rate replace data within 250 us.
// - When the signal returns, all-ones stops and line data resumes within 250 us.
// - Signal loss is reported to equipment management only in monitoring state.
// - Lower line rate is 8448 kbit/s within 30 ppm.
// - Higher line rate is 34368 kbit/s within 20 ppm.
package pbc_pkg;
  // ********************************************************************
  // rates and clocks
  // ********************************************************************
  localparam int unsigned     PBC_MCLK_KHZ  = 200000;
  localparam int unsigned     PBC_RATE_LO   = 8448;   // kbit/s
  localparam int unsigned     PBC_PPM_LO    = 30;
  localparam int unsigned     PBC_RATE_HI   = 34368;  // kbit/s
  localparam int unsigned     PBC_PPM_HI    = 20;
  localparam int unsigned     PBC_BYTE_W    = 8;
  localparam int unsigned     PBC_BUF_DEPTH = 2;
  // 32-bit phase step: rounding error is a few ppb, far inside the ppm window
  localparam longint unsigned PBC_PHASE_ONE = 64'h1_0000_0000;
  localparam logic [31:0]     PBC_NCO_LO    =
    32'((PBC_PHASE_ONE * PBC_RATE_LO + PBC_MCLK_KHZ / 2) / PBC_MCLK_KHZ);
  localparam logic [31:0]     PBC_NCO_HI    =
    32'((PBC_PHASE_ONE * PBC_RATE_HI + PBC_MCLK_KHZ / 2) / PBC_MCLK_KHZ);
  localparam logic [31:0]     PBC_NCO_RST   = 32'h0;
  // byte spacing of the substitute stream in MCLK cycles
  localparam int unsigned     PBC_GAP_LO    = PBC_BYTE_W * PBC_MCLK_KHZ / PBC_RATE_LO;
  localparam int unsigned     PBC_GAP_HI    = PBC_BYTE_W * PBC_MCLK_KHZ / PBC_RATE_HI;
  // ********************************************************************
  // alarm timing and loss detection
  // ********************************************************************
  localparam int unsigned     PBC_AIS_US    = 250;
  localparam int unsigned     PBC_AIS_CYC   = PBC_AIS_US * PBC_MCLK_KHZ / 1000;
  localparam logic [9:0]      PBC_LOS_LO    = 10'h0FF;  // about 30 us of silence
  localparam logic [9:0]      PBC_LOS_HI    = 10'h3FF;  // about 30 us of silence
  localparam logic [7:0]      PBC_IDLE_BYTE = 8'hFF;
  localparam logic [7:0]      PBC_AIS_BYTE  = 8'hFF;
  localparam logic [2:0]      PBC_LAST_BIT  = 3'h7;
  // ********************************************************************
  // types
  // ********************************************************************
  typedef enum logic [1:0] {PBC_SYM_ZERO, PBC_SYM_MARK, PBC_SYM_BPOL, PBC_SYM_VIOL} pbc_sym_t;
  typedef enum logic {PBC_RX_LINE, PBC_RX_ALARM} pbc_rxmode_t;
endpackage

//--- test_pbc_line_codec.sv
// test_pbc_line_codec.sv: self-checking bench of the bipolar line codec
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("mismatch at %0t: value differs", $time); end end
module test_pbc_line_codec;
  import pbc_pkg::*;
  logic       MCLK, ARST_N, LINE_CLK, RATE_SEL, MON_EN, TX_VALID, TX_READY;
  logic       TX_POS, TX_NEG, RX_POS, RX_NEG, RX_VALID, RX_BCLK, SIGNAL_LOSS_DEFECT, LOS_REPORT;
  logic [7:0] TX_DATA, RX_DATA;
  logic       cut;
  int         code_err, errors, checked, gap;
  pbc_line_codec #(.AIS_LIMIT_CYC(1000)) dut_u (.MCLK(MCLK), .ARST_N(ARST_N),
    .LINE_CLK(LINE_CLK), .RATE_SEL(RATE_SEL), .MON_EN(MON_EN), .TX_DATA(TX_DATA),
    .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_POS(TX_POS), .TX_NEG(TX_NEG),
    .RX_POS(RX_POS), .RX_NEG(RX_NEG), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
    .RX_BCLK(RX_BCLK), .SIGNAL_LOSS_DEFECT(SIGNAL_LOSS_DEFECT), .LOS_REPORT(LOS_REPORT));
  pbc_line_partner far_u (.line_clk(LINE_CLK), .tx_pos(TX_POS), .tx_neg(TX_NEG), .cut(cut),
    .rx_pos(RX_POS), .rx_neg(RX_NEG), .code_err(code_err));
  // ********************************************************************
  // clocks and helpers
  // ********************************************************************
  initial begin MCLK = 0; forever #2.5 MCLK = ~MCLK; end
  initial begin LINE_CLK = 0; #3.3; forever #7.5 LINE_CLK = ~LINE_CLK; end
  task automatic step(int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  // waits for one delivered byte, counts the gap and checks the byte clock toggles
  task automatic next_byte();
    logic b;
    b = RX_BCLK;
    gap = 0;
    do begin step(1); gap++; end while (RX_VALID !== 1'b1 && gap < 2000);
    `CHK(RX_BCLK, ~b)
  endtask
  task automatic wait_los(logic v);
    int n;
    n = 0;
    while (SIGNAL_LOSS_DEFECT !== v && n < 50000) begin step(1); n++; end
    `CHK(SIGNAL_LOSS_DEFECT, v)
  endtask
  // back-to-back offers of zero bytes fill the buffer until it refuses
  task automatic t_zeros();
    int n;
    TX_DATA = 8'h00;
    TX_VALID = 1'b1;
    n = 0;
    while (TX_READY !== 1'b0 && n < 200) begin step(1); n++; end
    `CHK(TX_READY, 1'b0)
    repeat (30) next_byte();
    repeat (4) begin next_byte(); `CHK(RX_DATA, 8'h00) end
    TX_VALID = 1'b0;
    repeat (12) next_byte();
    `CHK(RX_DATA, PBC_IDLE_BYTE)
    $display("test zeros done");
  endtask
  // cut the line, check alarm stream, report and spacing, then restore
  task automatic t_loss(logic rate, logic mon, int g);
    RATE_SEL = rate;
    MON_EN = mon;
    TX_DATA = 8'h00;
    TX_VALID = 1'b1;
    repeat (20) next_byte();
    cut = 1'b1;
    wait_los(1'b1);
    step(3);
    `CHK(LOS_REPORT, mon)
    repeat (3) next_byte();
    `CHK(RX_DATA, PBC_AIS_BYTE)
    `CHK(gap == g || gap == g + 1, 1'b1)
    cut = 1'b0;
    wait_los(1'b0);
    `CHK(LOS_REPORT, 1'b0)
    repeat (6) next_byte();
    `CHK(RX_DATA, 8'h00)
    TX_VALID = 1'b0;
    // let an edge pass so a following call does not raise valid in the same step
    step(1);
    $display("test loss done");
  endtask
  task automatic report_and_stop();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ********************************************************************
  // main sequence and watchdog
  // ********************************************************************
  initial begin
    {ARST_N, RATE_SEL, MON_EN, TX_VALID, cut} = 5'h00;
    TX_DATA = 8'h00;
    errors = 0;
    checked = 0;
    repeat (3) @(posedge LINE_CLK);
    step(1);
    `CHK({TX_READY, RX_VALID, RX_BCLK, SIGNAL_LOSS_DEFECT, LOS_REPORT, TX_POS, TX_NEG, RX_DATA}, 15'h4000)
    ARST_N = 1'b1;
    step(2);
    t_zeros();
    t_loss(1'b0, 1'b1, 189);
    t_loss(1'b1, 1'b0, 46);
    t_loss(1'b1, 1'b1, 46);
    `CHK(code_err, 0)
    report_and_stop();
  end
  // whole run should need well under 60000 cycles
  initial begin
    #400000;
    errors++;
    report_and_stop();
  end
endmodule // test_pbc_line_codec
